// ---- common/flc_pkg.sv ----
// Purpose: constants shared by the flash command host controller
// Assumes: 100 MHz clock, 16-bit flash data bus, 21-bit byte-mode address
// Notes: timing counts derive from figures in ns; the read pulse adds SYNC_STAGES cycles
package flc_pkg;
  // Clock and bus cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TWP_NS = 35; // Write pulse least width
  localparam int TWPH_NS = 30; // Pulse high least time
  localparam int TACC_NS = 70; // Read access time
  localparam int TRP_NS = 500; // Reset pin low least width
  localparam int TRH_NS = 50; // Recovery after reset pin release
  localparam int SYNC_STAGES = 2;
  localparam int TWP_CYC = (TWP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TWPH_CYC = (TWPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TACC_CYC = (TACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRP_CYC = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRH_CYC = (TRH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_PULSE_CYC = TACC_CYC + SYNC_STAGES;

  // Widths
  localparam int ADDR_W = 21;
  localparam int DQ_W = 16;
  localparam int BANK_LSB = 12; // This address bit and those above it select the bank

  // Command codes and unlock addresses
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
  localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [15:0] CMD_BYPASS = 16'h0020;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] CMD_RESET = 16'h00F0;
  localparam logic [15:0] CMD_BYP_EXIT1 = 16'h0090;
  localparam logic [15:0] CMD_BYP_EXIT2 = 16'h0000;
  localparam logic [20:0] UNLOCK1_WORD = 21'h000555;
  localparam logic [20:0] UNLOCK2_WORD = 21'h0002AA;
  localparam logic [20:0] UNLOCK1_BYTE = 21'h000AAA;
  localparam logic [20:0] UNLOCK2_BYTE = 21'h000555;

  // Status bit positions on the data bus
  localparam int POLL_BIT = 7;
  localparam int LIMIT_BIT = 5;

  // Software operations
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_RESET = 4'h1,
    OP_AUTOSEL = 4'h2,
    OP_PROGRAM = 4'h3,
    OP_BYP_ENTER = 4'h4,
    OP_BYP_PROGRAM = 4'h5,
    OP_BYP_EXIT = 4'h6,
    OP_CHIP_ERASE = 4'h7,
    OP_HW_RESET = 4'h8
  } flc_op_e;

  // Register offsets
  localparam logic [7:0] REG_CMD_OFS = 8'h00;
  localparam logic [7:0] REG_CTRL_OFS = 8'h04;
  localparam logic [7:0] REG_ADDR_OFS = 8'h08;
  localparam logic [7:0] REG_DATA_OFS = 8'h0C;
  localparam logic [7:0] REG_STATUS_OFS = 8'h10;
  localparam logic [7:0] REG_RDATA_OFS = 8'h14;

  // Control fields
  localparam int CTRL_BYTE_BIT = 0;
  localparam int CTRL_ACCEL_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_AUTOSEL_BIT = 1;
  localparam int ST_BYPASS_BIT = 2;
  localparam int ST_RDYBSY_BIT = 3;
  localparam int ST_REJECT_BIT = 4;
  localparam int ST_LIMIT_BIT = 5;
  localparam int ST_DONE_BIT = 6;
endpackage

// ---- logic/flc_bus_cycle.sv ----
// Purpose: one asynchronous flash bus cycle, write or read
// Assumes: start is one cycle long and only given while idle
// Notes: data pins pass two flip-flops before being captured
`timescale 1ns/1ps
module flc_bus_cycle
  import flc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic isWrite,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire logic [DQ_W-1:0] dataIn,
  output logic done,
  output logic [DQ_W-1:0] rdata,
  output logic [ADDR_W-1:0] flashAddr,
  input wire logic [DQ_W-1:0] flashDqIn,
  output logic [DQ_W-1:0] flashDqOut,
  output logic flashDqOeN,
  output logic flashCeN,
  output logic flashWeN,
  output logic flashOeN
);
  typedef enum logic [3:0] {
    BC_IDLE = 4'b0001,
    BC_SETUP = 4'b0010,
    BC_PULSE = 4'b0100,
    BC_HOLD = 4'b1000
  } flc_bc_e;

  flc_bc_e bcState_reg;
  logic [7:0] cnt_reg;
  logic wr_reg;
  logic [DQ_W-1:0] dqMeta_reg;
  logic [DQ_W-1:0] dqSync_reg;

  // Data pin synchroniser
  always_ff @(posedge clk) begin
    dqMeta_reg <= flashDqIn;
    dqSync_reg <= dqMeta_reg;
  end

  // Cycle sequencing and strobes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bcState_reg <= BC_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      done <= 1'b0;
      flashCeN <= 1'b1;
      flashWeN <= 1'b1;
      flashOeN <= 1'b1;
      flashDqOeN <= 1'b1;
    end else begin
      done <= 1'b0;
      case (bcState_reg)
        BC_IDLE: begin
          if (start) begin
            wr_reg <= isWrite;
            flashCeN <= 1'b0;
            flashDqOeN <= ~isWrite;
            bcState_reg <= BC_SETUP;
          end
        end
        BC_SETUP: begin
          // Address already stable before the strobe falls
          flashWeN <= ~wr_reg;
          flashOeN <= wr_reg;
          cnt_reg <= wr_reg ? 8'(TWP_CYC - 1) : 8'(READ_PULSE_CYC - 1);
          bcState_reg <= BC_PULSE;
        end
        BC_PULSE: begin
          if (cnt_reg == 8'h00) begin
            // Data still driven as the strobe rises
            flashWeN <= 1'b1;
            flashOeN <= 1'b1;
            flashCeN <= 1'b1;
            cnt_reg <= 8'(TWPH_CYC - 1);
            bcState_reg <= BC_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        BC_HOLD: begin
          if (cnt_reg == 8'h00) begin
            flashDqOeN <= 1'b1;
            done <= 1'b1;
            bcState_reg <= BC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: bcState_reg <= BC_IDLE;
      endcase
    end
  end

  // Address, write data and read capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flashAddr <= '0;
      flashDqOut <= '0;
      rdata <= '0;
    end else begin
      if (bcState_reg == BC_IDLE && start) begin
        flashAddr <= addrIn;
        flashDqOut <= dataIn;
      end
      if (bcState_reg == BC_PULSE && cnt_reg == 8'h00 && !wr_reg) begin
        rdata <= dqSync_reg;
      end
    end
  end
endmodule // flc_bus_cycle

// ---- logic/flc_host_ctrl.sv ----
// Purpose: host controller issuing command sequences to a dual-bank NOR flash
// Assumes: software waits for busy low before the next command
// Notes: refused commands set a sticky flag and change nothing else
// Behaviour
// - Autoselect left by reset command or hardware reset
// - Autoselect only when other bank idle
// - Autoselect: two unlocks, bank address command
// - Program: two unlocks, setup, address data
// - Bypass entry: two unlocks then 20h
// - Bypass program: A0h then address data
// - Chip erase: six writes, ends 10h
// - Bad sequence needs reset to recover
`timescale 1ns/1ps
module flc_host_ctrl
  import flc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic [ADDR_W-1:0] flashAddr,
  input wire logic [DQ_W-1:0] flashDqIn,
  output logic [DQ_W-1:0] flashDqOut,
  output logic flashDqOeN,
  output logic flashCeN,
  output logic flashWeN,
  output logic flashOeN,
  output logic flashByteN,
  output logic flashRstN,
  output logic accelReq,
  input wire logic readyBusy
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_WRITE = 6'b000010,
    S_READ = 6'b000100,
    S_POLL = 6'b001000,
    S_HWRST = 6'b010000,
    S_HWREC = 6'b100000
  } flc_state_e;

  flc_state_e state_reg;
  flc_state_e state_next;
  flc_op_e op_reg;
  flc_op_e newOp;
  logic [1:0] ctrl_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DQ_W-1:0] data_reg;
  logic [2:0] step_reg;
  logic [2:0] lastStep;
  logic [ADDR_W-1:0] stepAddr;
  logic [DQ_W-1:0] stepData;
  logic [ADDR_W-1:0] unlock1;
  logic [ADDR_W-1:0] unlock2;
  logic [9:0] timer_reg;
  logic autosel_reg;
  logic bypass_reg;
  logic limitSeen_reg;
  logic pollExp_reg;
  logic rejectFlag_reg;
  logic limitFlag_reg;
  logic doneFlag_reg;
  logic rbMeta_reg;
  logic rbSync_reg;
  logic cycStart_reg;
  logic launch;
  logic cycDone;
  logic [DQ_W-1:0] cycRdata;
  logic bypassActive;
  logic cmdWrite;
  logic cmdLegal;
  logic cmdAccept;
  logic seqEnd;
  logic pollMatch;
  logic limitAbort;
  logic stsClear;

  flc_bus_cycle u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .start(cycStart_reg),
    .isWrite(state_reg != S_READ && state_reg != S_POLL),
    .addrIn(state_reg == S_WRITE ? stepAddr : addr_reg),
    .dataIn(stepData),
    .done(cycDone),
    .rdata(cycRdata),
    .flashAddr(flashAddr),
    .flashDqIn(flashDqIn),
    .flashDqOut(flashDqOut),
    .flashDqOeN(flashDqOeN),
    .flashCeN(flashCeN),
    .flashWeN(flashWeN),
    .flashOeN(flashOeN)
  );

  // Ready/busy pin synchroniser
  always_ff @(posedge clk) begin
    rbMeta_reg <= readyBusy;
    rbSync_reg <= rbMeta_reg;
  end

  // Command legality against the tracked device mode
  assign newOp = flc_op_e'(regWdata[3:0]);
  assign bypassActive = bypass_reg | ctrl_reg[CTRL_ACCEL_BIT];
  assign cmdWrite = regWr && regAddr == REG_CMD_OFS;
  always_comb begin
    cmdLegal = 1'b0;
    if (state_reg == S_IDLE) begin
      case (newOp)
        OP_HW_RESET: cmdLegal = 1'b1;
        OP_READ: cmdLegal = 1'b1;
        OP_BYP_PROGRAM, OP_BYP_EXIT: cmdLegal = bypassActive;
        OP_RESET: cmdLegal = !bypassActive;
        OP_AUTOSEL: cmdLegal = !bypassActive && !autosel_reg && rbSync_reg;
        OP_PROGRAM, OP_BYP_ENTER, OP_CHIP_ERASE: cmdLegal = !bypassActive && !autosel_reg;
        default: cmdLegal = 1'b0;
      endcase
    end
  end
  assign cmdAccept = cmdWrite && cmdLegal;

  // Unlock addresses follow byte or word mode
  assign unlock1 = ctrl_reg[CTRL_BYTE_BIT] ? UNLOCK1_BYTE : UNLOCK1_WORD;
  assign unlock2 = ctrl_reg[CTRL_BYTE_BIT] ? UNLOCK2_BYTE : UNLOCK2_WORD;

  // Address and data of each write in a sequence
  always_comb begin
    stepAddr = (step_reg == 3'd1 || step_reg == 3'd4) ? unlock2 : unlock1;
    stepData = (step_reg == 3'd1 || step_reg == 3'd4) ? CMD_UNLOCK2 : CMD_UNLOCK1;
    lastStep = 3'd2;
    case (op_reg)
      OP_RESET: begin
        stepAddr = addr_reg;
        stepData = CMD_RESET;
        lastStep = 3'd0;
      end
      OP_AUTOSEL: begin
        if (step_reg == 3'd2) begin
          stepAddr = {addr_reg[ADDR_W-1:BANK_LSB], unlock1[BANK_LSB-1:0]};
          stepData = CMD_AUTOSEL;
        end
      end
      OP_PROGRAM: begin
        lastStep = 3'd3;
        if (step_reg == 3'd2) stepData = CMD_PROGRAM;
        if (step_reg == 3'd3) begin
          stepAddr = addr_reg;
          stepData = data_reg;
        end
      end
      OP_BYP_ENTER: begin
        if (step_reg == 3'd2) stepData = CMD_BYPASS;
      end
      OP_BYP_PROGRAM: begin
        lastStep = 3'd1;
        stepAddr = addr_reg;
        stepData = (step_reg == 3'd0) ? CMD_PROGRAM : data_reg;
      end
      OP_BYP_EXIT: begin
        lastStep = 3'd1;
        stepAddr = addr_reg;
        stepData = (step_reg == 3'd0) ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2;
      end
      OP_CHIP_ERASE: begin
        lastStep = 3'd5;
        if (step_reg == 3'd2) stepData = CMD_ERASE_SETUP;
        if (step_reg == 3'd5) stepData = CMD_CHIP_ERASE;
      end
      default: lastStep = 3'd0;
    endcase
  end

  // Completion and status polling decisions
  assign seqEnd = state_reg == S_WRITE && cycDone && step_reg == lastStep;
  assign pollMatch = cycRdata[POLL_BIT] == pollExp_reg;
  assign limitAbort = state_reg == S_POLL && cycDone && !pollMatch
                      && cycRdata[LIMIT_BIT] && limitSeen_reg;

  // Sequencer transitions
  always_comb begin
    state_next = state_reg;
    launch = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (cmdAccept) begin
          case (newOp)
            OP_HW_RESET: state_next = S_HWRST;
            OP_READ: begin
              state_next = S_READ;
              launch = 1'b1;
            end
            default: begin
              state_next = S_WRITE;
              launch = 1'b1;
            end
          endcase
        end
      end
      S_WRITE: begin
        if (cycDone) begin
          launch = 1'b1;
          if (step_reg == lastStep) begin
            if (op_reg == OP_PROGRAM || op_reg == OP_BYP_PROGRAM || op_reg == OP_CHIP_ERASE) begin
              state_next = S_POLL;
            end else begin
              state_next = S_IDLE;
              launch = 1'b0;
            end
          end
        end
      end
      S_READ: begin
        if (cycDone) state_next = S_IDLE;
      end
      S_POLL: begin
        if (cycDone) begin
          if (pollMatch) begin
            state_next = S_IDLE;
          end else if (limitAbort) begin
            state_next = S_WRITE;
            launch = 1'b1;
          end else begin
            launch = 1'b1;
          end
        end
      end
      S_HWRST: begin
        if (timer_reg == 10'd0) state_next = S_HWREC;
      end
      S_HWREC: begin
        if (timer_reg == 10'd0) state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
  end

  // State and cycle launch registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cycStart_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cycStart_reg <= launch;
    end
  end

  // Operation, step and poll expectation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_reg <= OP_READ;
      step_reg <= 3'd0;
      pollExp_reg <= 1'b0;
      limitSeen_reg <= 1'b0;
    end else if (cmdAccept) begin
      op_reg <= newOp;
      step_reg <= 3'd0;
      limitSeen_reg <= 1'b0;
      pollExp_reg <= (newOp == OP_CHIP_ERASE) ? 1'b1 : data_reg[POLL_BIT];
    end else if (limitAbort) begin
      op_reg <= OP_RESET;
      step_reg <= 3'd0;
    end else if (state_reg == S_WRITE && cycDone && step_reg != lastStep) begin
      step_reg <= step_reg + 3'd1;
    end else if (state_reg == S_POLL && cycDone && cycRdata[LIMIT_BIT]) begin
      limitSeen_reg <= 1'b1;
    end
  end

  // Reset pin pulse and recovery timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_reg <= 10'd0;
      flashRstN <= 1'b1;
    end else if (cmdAccept && newOp == OP_HW_RESET) begin
      timer_reg <= 10'(TRP_CYC - 1);
      flashRstN <= 1'b0;
    end else if (state_reg == S_HWRST && timer_reg == 10'd0) begin
      timer_reg <= 10'(TRH_CYC - 1);
      flashRstN <= 1'b1;
    end else if (timer_reg != 10'd0) begin
      timer_reg <= timer_reg - 10'd1;
    end
  end

  // Tracked device modes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      autosel_reg <= 1'b0;
      bypass_reg <= 1'b0;
    end else if (state_reg == S_HWRST) begin
      autosel_reg <= 1'b0;
      bypass_reg <= 1'b0;
    end else if (seqEnd) begin
      case (op_reg)
        OP_AUTOSEL: autosel_reg <= 1'b1;
        OP_RESET: autosel_reg <= 1'b0;
        OP_BYP_ENTER: bypass_reg <= 1'b1;
        OP_BYP_EXIT: bypass_reg <= 1'b0;
        default: autosel_reg <= autosel_reg;
      endcase
    end
  end

  // Software control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
      addr_reg <= '0;
      data_reg <= '0;
    end else if (regWr) begin
      if (regAddr == REG_CTRL_OFS) ctrl_reg <= regWdata[1:0];
      if (regAddr == REG_ADDR_OFS && state_reg == S_IDLE) addr_reg <= regWdata[ADDR_W-1:0];
      if (regAddr == REG_DATA_OFS && state_reg == S_IDLE) data_reg <= regWdata[DQ_W-1:0];
    end
  end
  assign flashByteN = ~ctrl_reg[CTRL_BYTE_BIT];
  assign accelReq = ctrl_reg[CTRL_ACCEL_BIT];

  // Sticky flags, write one to clear, set wins
  assign stsClear = regWr && regAddr == REG_STATUS_OFS;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rejectFlag_reg <= 1'b0;
      limitFlag_reg <= 1'b0;
      doneFlag_reg <= 1'b0;
    end else begin
      rejectFlag_reg <= (cmdWrite && !cmdLegal)
                        | (rejectFlag_reg & ~(stsClear & regWdata[ST_REJECT_BIT]));
      limitFlag_reg <= limitAbort | (limitFlag_reg & ~(stsClear & regWdata[ST_LIMIT_BIT]));
      doneFlag_reg <= (state_reg != S_IDLE && state_next == S_IDLE)
                      | (doneFlag_reg & ~(stsClear & regWdata[ST_DONE_BIT]));
    end
  end

  // Read data, one cycle after the strobe; last flash read shows codes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        REG_CMD_OFS: regRdata <= {28'h0000000, op_reg};
        REG_CTRL_OFS: regRdata <= {30'h0, ctrl_reg};
        REG_ADDR_OFS: regRdata <= {11'h000, addr_reg};
        REG_DATA_OFS: regRdata <= {16'h0000, data_reg};
        REG_STATUS_OFS: regRdata <= {25'h0, doneFlag_reg, limitFlag_reg, rejectFlag_reg,
                                     rbSync_reg, bypassActive, autosel_reg,
                                     state_reg != S_IDLE};
        REG_RDATA_OFS: regRdata <= {16'h0000, cycRdata};
        default: regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end
endmodule // flc_host_ctrl

// ---- test/flc_flash_model.sv ----
// Purpose: behavioural flash device beside the host controller
// Assumes: one bank, array starts erased
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
module flc_flash_model
  import flc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'hC3, // Arbitrary value
  parameter int PGM_CYC = 40,
  parameter int ERS_CYC = 200
)
(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq,
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic byteN,
  input wire logic rstN,
  input wire logic accel,
  output logic [DQ_W-1:0] dqIn,
  output logic readyBusy
);
  logic [DQ_W-1:0] mem [int];
  logic [ADDR_W-1:0] la = '0;
  logic [DQ_W-1:0] rv;
  logic [DQ_W-1:0] lastV = '0;
  logic [DQ_W-1:0] pd = '0;
  logic [7:0] c;
  int stage = 0;
  int busy = 0;
  logic asel = 0, byp = 0, arm = 0, ext = 0, lim = 0, tog = 0, weP = 1, ceP = 1;
  function automatic logic [DQ_W-1:0] rd(logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : '1;
  endfunction
  assign c = dq[7:0];
  assign readyBusy = (busy == 0) && !lim;
  // Write decode, embedded timer, reset pin
  always @(posedge clk) begin
    if (weP && !weN) la = addr;
    if (busy > 0) busy = busy - 1;
    if (!rstN) begin
      stage = 0; busy = 0; asel = 0; byp = 0; arm = 0; lim = 0;
    end else if (!weP && weN && !ceP) begin
      if (lim) begin
        lim = !(c == 8'hF0);
        if (!lim) busy = 0;
      end else if (busy > 0) begin
        stage = stage;
      end else if (arm) begin
        pd = dq;
        lim = |(dq & ~rd(la));
        mem[la] = rd(la) & dq;
        busy = PGM_CYC;
        arm = 0;
      end else if (byp || accel) begin
        arm = c == 8'hA0;
        if (ext && c == 8'h00) byp = 0;
        ext = c == 8'h90;
      end else if (c == 8'hF0) begin
        stage = 0;
        asel = 0;
      end else begin
        case (stage)
          0: stage = (c == 8'hAA && la[11:0] == (byteN ? 12'h555 : 12'hAAA)) ? 1 : 0;
          1: stage = (c == 8'h55 && la[11:0] == (byteN ? 12'h2AA : 12'h555)) ? 2 : 0;
          2: begin
            asel = c == 8'h90;
            arm = c == 8'hA0;
            byp = c == 8'h20;
            stage = c == 8'h80 ? 3 : 0;
          end
          3: stage = c == 8'hAA ? 4 : 0;
          4: stage = c == 8'h55 ? 5 : 0;
          default: begin
            if (c == 8'h10) begin
              mem.delete();
              busy = ERS_CYC;
              pd = '1;
            end
            stage = 0;
          end
        endcase
      end
    end
    weP = weN;
    ceP = ceN;
  end
  // Toggle bits flip on each read
  always @(negedge oeN) tog = ~tog;
  // Read data: status, ids, or array
  always @* begin
    if (busy > 0 || lim) rv = {8'h00, ~pd[7], tog, lim, 2'b00, tog, 2'b00};
    else if (!asel) rv = rd(addr);
    else if (addr[7:0] == 8'h00) rv = {8'h00, MAKER_ID};
    else if (addr[7:0] == (byteN ? 8'h01 : 8'h02)) rv = {8'h00, DEV_ID};
    else if (addr[7:0] == (byteN ? 8'h02 : 8'h04)) rv = {15'h0, addr[11]};
    else rv = '0;
  end
  always @(posedge clk) if (!oeN && !ceN) lastV <= rv;
  assign dqIn = (!oeN && !ceN) ? rv : ~lastV;
endmodule // flc_flash_model

// ---- test/flc_host_ctrl_assertions.sv ----
// Purpose: concurrent checks on the flash pins of the controller
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every controller instance
`timescale 1ns/1ps
module flc_host_ctrl_assertions
  import flc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic [DQ_W-1:0] flashDqOut,
  input wire logic flashDqOeN,
  input wire logic flashCeN,
  input wire logic flashWeN,
  input wire logic flashOeN,
  input wire logic flashByteN,
  input wire logic flashRstN
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Write strobe framing and hold
  a_we_inside_ce: assert property (!flashWeN |-> !flashCeN && !flashDqOeN)
    else $error("write strobe outside select");
  a_addr_held: assert property (!flashWeN && $past(!flashWeN) |->
    $stable(flashAddr) && $stable(flashDqOut)) else $error("address moved");
  a_we_width: assert property ($fell(flashWeN) |-> !flashWeN [*4])
    else $error("write pulse short");
  a_strobes_rise: assert property ($rose(flashWeN) |-> $rose(flashCeN))
    else $error("strobes rise apart");
  // Unlock addresses follow byte mode
  a_unlock1_addr: assert property (!flashWeN && flashDqOut[7:0] == 8'hAA |->
    flashAddr[11:0] == (flashByteN ? 12'h555 : 12'hAAA)) else $error("unlock1 addr");
  a_unlock2_addr: assert property (!flashWeN && flashDqOut[7:0] == 8'h55 |->
    flashAddr[11:0] == (flashByteN ? 12'h2AA : 12'h555)) else $error("unlock2 addr");
  a_read_released: assert property (!flashOeN |-> flashDqOeN && flashWeN)
    else $error("read while driving");
  a_rst_hold: assert property ($fell(flashRstN) |-> !flashRstN [*8])
    else $error("reset pulse short");
  cover property ($fell(flashRstN));
  cover property ($fell(flashWeN) && flashDqOut[7:0] == 8'hA0);
  cover property ($fell(flashOeN) && !flashByteN);
endmodule // flc_host_ctrl_assertions
bind flc_host_ctrl flc_host_ctrl_assertions u_chk (.clk(clk), .rst_n(rst_n),
  .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOeN(flashDqOeN),
  .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
  .flashByteN(flashByteN), .flashRstN(flashRstN));

// ---- test/tb_flc_host_ctrl.sv ----
// Purpose: self-checking bench for the flash host controller
// Assumes: behavioural flash model on the pins
// Notes: random program data, fixed seed
`timescale 1ns/1ps
module tb_flc_host_ctrl
  import flc_pkg::*;
;
  logic clk = 0, rst_n = 0, regWr = 0, regRd = 0;
  logic [7:0] regAddr = '0;
  logic [31:0] regWdata = '0, regRdata, st, rv;
  logic [ADDR_W-1:0] flashAddr, a;
  logic [DQ_W-1:0] flashDqIn, flashDqOut, d, d2;
  logic flashDqOeN, flashCeN, flashWeN, flashOeN, flashByteN, flashRstN, accelReq, readyBusy;
  int err_total = 0;
  int compares = 0;
  always #5 clk = ~clk;
  flc_host_ctrl uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr),
    .flashDqIn(flashDqIn), .flashDqOut(flashDqOut), .flashDqOeN(flashDqOeN),
    .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN), .flashByteN(flashByteN),
    .flashRstN(flashRstN), .accelReq(accelReq), .readyBusy(readyBusy));
  flc_flash_model #(.MAKER_ID(8'h5A), .DEV_ID(8'hC3)) fm (.clk(clk), .addr(flashAddr),
    .dq(flashDqOut), .ceN(flashCeN), .weN(flashWeN), .oeN(flashOeN), .byteN(flashByteN),
    .rstN(flashRstN), .accel(accelReq), .dqIn(flashDqIn), .readyBusy(readyBusy));
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Register bus cycles
  task automatic wr(logic [7:0] ad, logic [31:0] v);
    @(posedge clk);
    regAddr <= ad;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, output logic [31:0] v);
    @(posedge clk);
    regAddr <= ad;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    do begin
      rd(REG_STATUS_OFS, st);
      n++;
    end while (st[ST_BUSY_BIT] !== 1'b0 && n < 5000);
    if (n >= 5000) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic cmd(flc_op_e op);
    wr(REG_CMD_OFS, 32'(op));
    idle();
  endtask
  task automatic prog(flc_op_e op, logic [ADDR_W-1:0] ad, logic [DQ_W-1:0] v);
    wr(REG_ADDR_OFS, 32'(ad));
    wr(REG_DATA_OFS, 32'(v));
    cmd(op);
  endtask
  task automatic rmem(logic [ADDR_W-1:0] ad);
    wr(REG_ADDR_OFS, 32'(ad));
    cmd(OP_READ);
    rd(REG_RDATA_OFS, rv);
  endtask
  initial begin
    void'($urandom(4));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_STATUS_OFS, st);
    chk("status", 32'(st[6:0]), 32'h08);
    for (int bm = 0; bm < 2; bm++) begin
      wr(REG_CTRL_OFS, 32'(bm));
      wr(REG_ADDR_OFS, 32'h18000);
      cmd(OP_AUTOSEL);
      chk("autosel", 32'(st[ST_AUTOSEL_BIT]), 32'h1);
      rmem(21'h18000);
      chk("maker", 32'(rv[7:0]), 32'h5A);
      rmem(bm ? 21'h18002 : 21'h18001);
      chk("device", 32'(rv[7:0]), 32'hC3);
      rmem(bm ? 21'h18804 : 21'h18802);
      chk("prot", 32'(rv[7:0]), 32'h01);
      rmem(bm ? 21'h18004 : 21'h18002);
      chk("unprot", 32'(rv[7:0]), 32'h00);
      cmd(OP_PROGRAM);
      chk("refuse", 32'(st[ST_REJECT_BIT]), 32'h1);
      wr(REG_STATUS_OFS, 32'h70);
      cmd(OP_RESET);
      chk("leave", 32'(st[ST_AUTOSEL_BIT]), 32'h0);
    end
    wr(REG_CTRL_OFS, 32'h0);
    rmem(21'h18000);
    chk("array", 32'(rv[15:0]), 32'hFFFF);
    $display("autoselect test done");
    for (int i = 0; i < 4; i++) begin
      a = 21'(((i + 1) << 8) | ($urandom & 32'hF0));
      d = 16'($urandom);
      d[3:0] = 4'h3;
      d2 = 16'($urandom);
      d2[3:0] = 4'h1;
      prog(OP_PROGRAM, a, d);
      rmem(a);
      chk("pgm", 32'(rv[15:0]), 32'(d));
      prog(OP_PROGRAM, a, d2);
      chk("limit", 32'(st[ST_LIMIT_BIT]), 32'(|(d2 & ~d)));
      wr(REG_STATUS_OFS, 32'h70);
      rmem(a);
      chk("clear", 32'(rv[15:0]), 32'(d & d2));
    end
    $display("program test done");
    cmd(OP_BYP_ENTER);
    chk("byp", 32'(st[ST_BYPASS_BIT]), 32'h1);
    cmd(OP_RESET);
    chk("bypref", 32'(st[ST_REJECT_BIT]), 32'h1);
    wr(REG_STATUS_OFS, 32'h70);
    prog(OP_BYP_PROGRAM, 21'h00800, 16'h1233);
    prog(OP_BYP_PROGRAM, 21'h00801, 16'h4563);
    cmd(OP_BYP_EXIT);
    chk("bypx", 32'(st[ST_BYPASS_BIT]), 32'h0);
    rmem(21'h00800);
    chk("byp0", 32'(rv[15:0]), 32'h1233);
    rmem(21'h00801);
    chk("byp1", 32'(rv[15:0]), 32'h4563);
    wr(REG_CTRL_OFS, 32'h2);
    @(negedge clk);
    chk("accel", 32'(accelReq), 32'h1);
    prog(OP_BYP_PROGRAM, 21'h00802, 16'h0F03);
    wr(REG_CTRL_OFS, 32'h0);
    rmem(21'h00802);
    chk("accpgm", 32'(rv[15:0]), 32'h0F03);
    $display("bypass test done");
    wr(REG_CMD_OFS, 32'(OP_CHIP_ERASE));
    wr(REG_CMD_OFS, 32'(OP_PROGRAM));
    idle();
    chk("ersref", 32'(st[ST_REJECT_BIT]), 32'h1);
    rmem(21'h00800);
    chk("erased", 32'(rv[15:0]), 32'hFFFF);
    cmd(OP_BYP_ENTER);
    wr(REG_CMD_OFS, 32'(OP_HW_RESET));
    repeat (2) @(posedge clk);
    chk("rstpin", 32'(flashRstN), 32'h0);
    idle();
    chk("rstbyp", 32'(st[ST_BYPASS_BIT]), 32'h0);
    $display("erase and reset test done");
    test_done();
  end
endmodule // tb_flc_host_ctrl
